// >>> rtl/sub_datapath_regs.vh
`ifndef SUB_DATAPATH_REGS_VH
`define SUB_DATAPATH_REGS_VH

// Register byte offsets on the APB side
`define OFS_INSTR        8'h00
`define OFS_ACC          8'h04
`define OFS_STATUS       8'h08
`define OFS_MEM_ADDR     8'h0C
`define OFS_MEM_DATA     8'h10
`define OFS_LAST_RESULT  8'h14
`define OFS_EXEC_COUNT   8'h18

// Status register bit positions
`define STAT_C           0
`define STAT_DC          1
`define STAT_Z           2

// Reset values
`define RST_ACC          8'h00
`define RST_STATUS       8'h00
`define RST_MEM_ADDR     7'h00
`define RST_LAST_RESULT  8'h00
`define RST_EXEC_COUNT   16'h0000

// Instruction word layout (14 bits)
`define INSTR_MSB        13
`define OPC_LIT_TOP      5'h1E
`define OPC_REG_TOP      6'h02
`define INSTR_DEST_BIT   7
`define INSTR_FADDR_MSB  6
`define INSTR_LIT_MSB    7

// Data memory
`define MEM_DEPTH        128
`define MEM_AW           7

// Access phase length in clock cycles while pready is low
`define APB_WAIT_CYCLES  1

`endif

// >>> rtl/sub_alu.v
`timescale 1ns/100ps
// Computes minuend - subtrahend by adding the inverted subtrahend plus one,
// so every carry out is an inverted borrow.
module sub_alu (
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    output wire [7:0] result,
    output wire       carry,
    output wire       digit_carry,
    output wire       zero
);

    wire [8:0] full_sum;
    wire [4:0] low_sum;

    assign full_sum    = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    assign low_sum     = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    assign result      = full_sum[7:0];
    // Set when no borrow: result is positive or zero
    assign carry       = full_sum[8];
    assign digit_carry = low_sum[4];
    assign zero        = (full_sum[7:0] == 8'h00);

endmodule // sub_alu

// >>> rtl/sub_datapath.v
`timescale 1ns/100ps
`include "sub_datapath_regs.vh"

// Behaviour
// - Literal minus accumulator always lands in accumulator
// - Addressed register minus accumulator, 7-bit address
// - Destination bit selects accumulator or register
// - Update carry, digit carry, zero; keep others
// - Carry is inverted borrow, result wraps 256
module sub_datapath (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output wire [7:0]  acc_out,
    output wire        carry_flag,
    output wire        digit_carry_flag,
    output wire        zero_flag
);

    localparam [2:0] IDX_INSTR  = 3'd0;
    localparam [2:0] IDX_ACC    = 3'd1;
    localparam [2:0] IDX_STATUS = 3'd2;
    localparam [2:0] IDX_MADDR  = 3'd3;
    localparam [2:0] IDX_MDATA  = 3'd4;
    localparam [2:0] IDX_LAST   = 3'd5;
    localparam [2:0] IDX_COUNT  = 3'd6;
    localparam [2:0] IDX_NONE   = 3'd7;

    // One-hot bus phases
    localparam [2:0] PH_IDLE    = 3'b001;
    localparam [2:0] PH_SETUP   = 3'b010;
    localparam [2:0] PH_RESP    = 3'b100;

    // Maps a byte address onto a register index
    function [2:0] reg_index;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_INSTR:       reg_index = IDX_INSTR;
                `OFS_ACC:         reg_index = IDX_ACC;
                `OFS_STATUS:      reg_index = IDX_STATUS;
                `OFS_MEM_ADDR:    reg_index = IDX_MADDR;
                `OFS_MEM_DATA:    reg_index = IDX_MDATA;
                `OFS_LAST_RESULT: reg_index = IDX_LAST;
                `OFS_EXEC_COUNT:  reg_index = IDX_COUNT;
                default:          reg_index = IDX_NONE;
            endcase
        end
    endfunction

    // Literal form: top bits 11 110x
    function is_lit_op;
        input [31:0] word;
        begin
            is_lit_op = (word[`INSTR_MSB:`INSTR_MSB-4] == `OPC_LIT_TOP);
        end
    endfunction

    // Register form: top bits 00 0010
    function is_reg_op;
        input [31:0] word;
        begin
            is_reg_op = (word[`INSTR_MSB:`INSTR_MSB-5] == `OPC_REG_TOP);
        end
    endfunction

    reg  [7:0]  acc_q;
    reg  [7:0]  acc_d;
    reg  [7:0]  status_q;
    reg  [7:0]  status_d;
    reg  [6:0]  mem_addr_q;
    reg  [7:0]  last_q;
    reg  [15:0] count_q;
    reg  [7:0]  mem [0:`MEM_DEPTH-1];

    // Bus phase state
    reg  [2:0]  phase_q;
    reg  [2:0]  phase_d;

    reg  [31:0] rd_data;
    reg         rd_err;
    reg         mem_we;
    reg  [6:0]  mem_wa;
    reg  [7:0]  mem_wd;
    reg         exec_en;

    wire        access;
    wire        done;
    wire        commit;
    wire [2:0]  wr_idx;
    wire [2:0]  rd_idx;
    wire        op_lit;
    wire        op_reg;
    wire        op_dest;
    wire [6:0]  op_faddr;
    wire [7:0]  minuend;
    wire [7:0]  diff;
    wire        diff_c;
    wire        diff_dc;
    wire        diff_z;

    assign access   = psel & penable;
    // The write and any instruction take effect only at this edge
    assign done     = access & pready;
    // A refused write leaves every register as it was
    assign commit   = done & pwrite & ~pslverr;
    assign wr_idx   = reg_index(paddr);
    assign rd_idx   = reg_index(paddr);
    assign op_lit   = is_lit_op(pwdata);
    assign op_reg   = is_reg_op(pwdata);
    assign op_dest  = pwdata[`INSTR_DEST_BIT];
    assign op_faddr = pwdata[`INSTR_FADDR_MSB:0];

    // Minuend is the literal or the addressed memory byte
    assign minuend  = op_lit ? pwdata[`INSTR_LIT_MSB:0] : mem[op_faddr];

    sub_alu u_alu (
        .minuend     (minuend),
        .subtrahend  (acc_q),
        .result      (diff),
        .carry       (diff_c),
        .digit_carry (diff_dc),
        .zero        (diff_z)
    );

    assign acc_out          = acc_q;
    assign carry_flag       = status_q[`STAT_C];
    assign digit_carry_flag = status_q[`STAT_DC];
    assign zero_flag        = status_q[`STAT_Z];

    // Read mux and error check, sampled in the first access cycle
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (rd_idx)
            IDX_INSTR: begin
                rd_data = 32'h0000_0000;
                rd_err  = pwrite & ~(is_lit_op(pwdata) | is_reg_op(pwdata));
            end
            IDX_ACC: begin
                rd_data = {24'h000000, acc_q};
            end
            IDX_STATUS: begin
                rd_data = {24'h000000, status_q};
            end
            IDX_MADDR: begin
                rd_data = {25'h0, mem_addr_q};
            end
            IDX_MDATA: begin
                rd_data = {24'h000000, mem[mem_addr_q]};
            end
            IDX_LAST: begin
                rd_data = {24'h000000, last_q};
                rd_err  = pwrite;
            end
            IDX_COUNT: begin
                rd_data = {16'h0000, count_q};
                rd_err  = pwrite;
            end
            default: begin
                rd_data = 32'h0000_0000;
                rd_err  = 1'b1;
            end
        endcase
    end

    // Next state of accumulator, status and memory port
    always @* begin
        acc_d    = acc_q;
        status_d = status_q;
        mem_we   = 1'b0;
        mem_wa   = mem_addr_q;
        mem_wd   = pwdata[7:0];
        exec_en  = 1'b0;
        if (commit) begin
            case (wr_idx)
                IDX_INSTR: begin
                    // Whole instruction completes at this single edge
                    exec_en = 1'b1;
                    if (op_lit) begin
                        acc_d = diff;
                    end else if (op_reg) begin
                        if (op_dest) begin
                            mem_we = 1'b1;
                            mem_wa = op_faddr;
                            mem_wd = diff;
                        end else begin
                            acc_d = diff;
                        end
                    end
                    // Only the three arithmetic flags move
                    status_d[`STAT_C]  = diff_c;
                    status_d[`STAT_DC] = diff_dc;
                    status_d[`STAT_Z]  = diff_z;
                end
                IDX_ACC: begin
                    acc_d = pwdata[7:0];
                end
                IDX_STATUS: begin
                    status_d = pwdata[7:0];
                end
                IDX_MDATA: begin
                    mem_we = 1'b1;
                end
                default: begin
                    acc_d = acc_q;
                end
            endcase
        end
    end

    // Bus phase; RESP is the one cycle with pready high
    always @* begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (psel & ~penable) begin
                    phase_d = PH_SETUP;
                end else if (access) begin
                    // Tolerate a master that skips the setup cycle
                    phase_d = PH_RESP;
                end
            end
            PH_SETUP: begin
                // Setup may be stretched; stay until penable rises
                if (access) begin
                    phase_d = PH_RESP;
                end else if (~psel) begin
                    phase_d = PH_IDLE;
                end
            end
            PH_RESP: begin
                phase_d = PH_IDLE;
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    // APB handshake: one wait cycle so read data comes from a flop
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= PH_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            phase_q <= phase_d;
            // Same next value as the phase bit, kept as its own output flop
            pready  <= (phase_d == PH_RESP);
            if (access & ~pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= rd_err;
            end else if (done) begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Architectural state
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q      <= `RST_ACC;
            status_q   <= `RST_STATUS;
            mem_addr_q <= `RST_MEM_ADDR;
            last_q     <= `RST_LAST_RESULT;
            count_q    <= `RST_EXEC_COUNT;
        end else begin
            acc_q    <= acc_d;
            status_q <= status_d;
            // Only the low seven bits address the memory
            if (commit & (wr_idx == IDX_MADDR)) begin
                mem_addr_q <= pwdata[`MEM_AW-1:0];
            end
            if (exec_en) begin
                // Result wraps modulo 256 in the 8-bit datapath
                last_q  <= diff;
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Data memory has no reset; a large array cleared on reset costs area
    // Bytes never written read as unknown until software fills them
    always @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

endmodule // sub_datapath

// >>> tb/sub_datapath_asserts.sv
`timescale 1ns/100ps
module sub_datapath_asserts (
    input wire        mclk,
    input wire        arst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [7:0]  acc_out,
    input wire        carry_flag,
    input wire        digit_carry_flag,
    input wire        zero_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire go = psel & penable & pready & pwrite & (paddr == 8'h00);
    sequence lit_go;
        go && pwdata[13:9] == 5'h1E;
    endsequence
    sequence mem_go;
        go && pwdata[13:7] == 7'h05;
    endsequence
    a_ready_one_wait: assert property ($rose(psel & penable) |-> !pready ##1 pready)
        else $error("pready timing wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_lit_result: assert property (lit_go |=> acc_out == $past(pwdata[7:0]) - $past(acc_out))
        else $error("literal result wrong");
    a_lit_borrow: assert property (lit_go |=> carry_flag == ($past(pwdata[7:0]) >= $past(acc_out)))
        else $error("carry wrong");
    a_lit_nibble: assert property (lit_go |=> digit_carry_flag == ($past(pwdata[3:0]) >= $past(acc_out[3:0])))
        else $error("digit carry wrong");
    a_lit_zero: assert property (lit_go |=> zero_flag == ($past(pwdata[7:0]) == $past(acc_out)))
        else $error("zero flag wrong");
    a_mem_keeps_acc: assert property (mem_go |=> $stable(acc_out))
        else $error("accumulator changed");
    a_flags_idle: assert property (!(psel & penable & pready & pwrite) |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("flags changed without write");
endmodule // sub_datapath_asserts
bind sub_datapath sub_datapath_asserts sub_datapath_asserts_i (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .acc_out(acc_out),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag));

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, er, dd;
    logic [7:0]  paddr = 8'h00, acc_out, r, a, k, m;
    logic [6:0]  f;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, carry_flag, digit_carry_flag, zero_flag;
    logic [7:0]  la[6] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h00, 8'h80};
    logic [7:0]  lk[6] = '{8'h02, 8'h02, 8'h02, 8'h0F, 8'hFF, 8'h7F};
    int          n_fail = 0, total_checks = 0, cyc = 0;
    always #2.5 mclk = ~mclk;
    sub_datapath sub_datapath_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_out(acc_out),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag));
    task test_done;
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds the request until pready is seen high at an edge
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
        chk("pslverr", {31'h0, er}, 32'h0);
    endtask
    task rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(nm, rd, e);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        rdc("acc", 8'h04, 32'h0);
        rdc("status", 8'h08, 32'h0);
        for (int i = 0; i < 6; i++) begin
            a = la[i]; k = lk[i]; r = k - a;
            wr(8'h08, 32'hF8);
            wr(8'h04, {24'h0, a});
            wr(8'h00, {18'h0, 5'h1E, i[0], k});
            rdc("acc", 8'h04, {24'h0, r});
            rdc("status", 8'h08, {24'h0, 5'h1F, r == 8'h00, k[3:0] >= a[3:0], k >= a});
        end
        // Top address and address zero, both destinations
        for (int i = 0; i < 4; i++) begin
            f = i[1] ? 7'h7F : 7'h00; dd = i[0]; m = 8'h03 - i[7:0]; a = 8'h02; r = m - a;
            wr(8'h0C, {25'h0, f});
            wr(8'h10, {24'h0, m});
            wr(8'h04, {24'h0, a});
            wr(8'h00, {18'h0, 6'h02, dd, f});
            rdc("mem", 8'h10, {24'h0, dd ? r : m});
            rdc("acc", 8'h04, {24'h0, dd ? a : r});
            chk("flags", {29'h0, zero_flag, digit_carry_flag, carry_flag},
                {29'h0, r == 8'h00, m[3:0] >= a[3:0], m >= a});
        end
        apb(1'b1, 8'h14, 32'h55);
        chk("ro write", {31'h0, er}, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        chk("bad opcode", {31'h0, er}, 32'h1);
        rdc("acc", 8'h04, 32'h2);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        rdc("last", 8'h14, 32'h000000FE);
        rdc("count", 8'h18, 32'h0000000A);
        test_done;
    end
endmodule // testbench
